// file: design/spio_defines.vh
// register map, field positions and reset values for the shared pin i/o ports
// Behaviour
// [RQ1] data latches of ports a..d sit at 12h, 14h, 16h, 18h
// [RQ2] direction registers sit at 13h, 15h, 17h, 19h above each latch
// [RQ3] port reads sample pins directly during the read, no input latch
// [RQ4] output latch holds written data until software rewrites it
// [RQ5] direction 1 makes line input, 0 drives latch onto pin
// [RQ6] read returns pin when direction 1, latch when direction 0
// [RQ7] after reset every line is an input
// [RQ8] bit set, clear and complement read whole port then write back
// [RQ9] any port a line can wake the device from halt
// [RQ10] port d has bit 0 only; upper bits read zero, writes ignored
// [RQ11] tone option with pd0 output drives tone; input mode stays normal
// [RQ12] pd0 latch 1 gates tone onto pin, 0 holds pin low
// [RQ13] tone toggles on each selected timer overflow
// [RQ14] comparator on, pin output off: pa1/pa2 analog, pa3 fall raises interrupt
// [RQ15] comparator and pin output on: pa3 carries comparator output, no latch/pull-up
// [RQ16] comparator in use disables pa1/pa2 digital i/o and pull-ups
// [RQ17] amplifier on: pa0, pb3 inputs, pb2 output, digital off
// [RQ18] port b converter input disables that line's digital i/o and pull-up
// [RQ19] true pulse enable routes to pc0/pc2/pc4 by pc7:pc6 select
// [RQ20] complement enable independently routes to pc1/pc3/pc5, same select
// [RQ21] pulse pin in output mode: latch 1 passes waveform, 0 holds low
// [RQ22] pc pin with direction 1 stays input, never outputs pulse
// [RQ23] tone fed from exactly one selected timer overflow
// [RQ24] pa3 falling edge gives single-cycle synchronous interrupt pulse
`ifndef SPIO_DEFINES_VH
`define SPIO_DEFINES_VH
`define SPIO_ADDR_PA     8'h12
`define SPIO_ADDR_PA_DIR 8'h13
`define SPIO_ADDR_PB     8'h14
`define SPIO_ADDR_PB_DIR 8'h15
`define SPIO_ADDR_PC     8'h16
`define SPIO_ADDR_PC_DIR 8'h17
`define SPIO_ADDR_PD     8'h18
`define SPIO_ADDR_PD_DIR 8'h19
`define SPIO_RST_PA      8'hff
`define SPIO_RST_PB      8'hff
`define SPIO_RST_PC      8'h3f
`define SPIO_RST_PD      1'b1
`define SPIO_RST_DIR     8'hff
`define SPIO_BIT_CMP_P   1
`define SPIO_BIT_CMP_N   2
`define SPIO_BIT_CMP_O   3
`define SPIO_BIT_OPA_P   0
`define SPIO_BIT_OPA_O   2
`define SPIO_BIT_OPA_N   3
`define SPIO_BIT_SEL_LO  6
`define SPIO_BIT_SEL_HI  7
`endif

// file: design/spio_edge.v
// synchronous falling-edge pulse detector for the comparator interrupt pin
`include "spio_defines.vh"
module spio_edge (
    input  wire mclk_i,
    input  wire srst_i,
    input  wire arm_i,
    input  wire level_i,
    output reg  pulse_o
);
    reg meta_q;
    reg sync_q;
    reg prev_q;
    // two flops before the edge test, inputs may still glitch
    always @(posedge mclk_i) begin
        if (srst_i) begin
            meta_q  <= 1'b1;
            sync_q  <= 1'b1;
            prev_q  <= 1'b1;
            pulse_o <= 1'b0;
        end else begin
            meta_q  <= level_i;
            sync_q  <= meta_q;
            prev_q  <= sync_q;
            pulse_o <= arm_i & prev_q & ~sync_q; // RQ24
        end
    end
endmodule

// file: design/spio_ports.v
// four shared-pin i/o ports with tone, comparator, amplifier and pulse muxing
`include "spio_defines.vh"
module spio_ports #(
    parameter W = 8
) (
    input  wire         mclk_i,
    input  wire         srst_i,
    input  wire [7:0]   addr_i,
    input  wire         wr_i,
    input  wire         rd_i,
    input  wire [7:0]   wdata_i,
    output reg  [7:0]   rdata_o,
    input  wire [W-1:0] pa_in_i,
    input  wire [W-1:0] pb_in_i,
    input  wire [W-1:0] pc_in_i,
    input  wire         pd_in_i,
    output reg  [W-1:0] pa_out_o,
    output reg  [W-1:0] pa_oe_o,
    output reg  [W-1:0] pa_pull_o,
    output reg  [W-1:0] pb_out_o,
    output reg  [W-1:0] pb_oe_o,
    output reg  [W-1:0] pb_pull_o,
    output reg  [W-1:0] pc_out_o,
    output reg  [W-1:0] pc_oe_o,
    output reg          pd_out_o,
    output reg          pd_oe_o,
    input  wire         comparator_enable_i,
    input  wire         comparator_pin_out_enable_i,
    input  wire         comparator_out_i,
    input  wire         amplifier_enable_i,
    input  wire [W-1:0] converter_sel_i,
    input  wire         tone_enable_i,
    input  wire         tone_src_sel_i,
    input  wire         timer0_ovf_i,
    input  wire         timer1_ovf_i,
    input  wire         true_pulse_out_enable_i,
    input  wire         complement_pulse_out_enable_i,
    input  wire [2:0]   pulse_i,
    input  wire [2:0]   pulse_n_i,
    output reg          cmp_irq_o,
    output reg          wake_o
);
    reg  [W-1:0] pa_q;
    reg  [W-1:0] pa_dir_q;
    reg  [W-1:0] pb_q;
    reg  [W-1:0] pb_dir_q;
    reg  [W-1:0] pc_q;
    reg  [W-1:0] pc_dir_q;
    reg          pd_q;
    reg          pd_dir_q;
    reg          tone_q;
    reg  [W-1:0] pa_prev_q;
    reg  [W-1:0] pa_dig;
    reg  [W-1:0] pb_dig;
    reg  [W-1:0] pc_pwm;
    reg  [W-1:0] pc_wave;
    reg  [W-1:0] pa_rd;
    reg  [W-1:0] pb_rd;
    reg  [W-1:0] pc_rd;
    reg  [7:0]   rd_d;
    reg  [2:0]   chan_sel;
    wire         cmp_on;
    wire         cmp_pin;
    wire         tone_tick;
    wire         cmp_fall;
    integer      i;

    assign cmp_on    = comparator_enable_i;
    assign cmp_pin   = comparator_enable_i & comparator_pin_out_enable_i;
    // only one overflow feeds the divider at any time
    assign tone_tick = tone_src_sel_i ? timer1_ovf_i : timer0_ovf_i; // RQ23

    // lines whose digital function is still alive
    always @* begin
        pa_dig = {W{1'b1}};
        pb_dig = ~converter_sel_i; // RQ18
        if (cmp_on) begin
            pa_dig[`SPIO_BIT_CMP_P] = 1'b0; // RQ16
            pa_dig[`SPIO_BIT_CMP_N] = 1'b0; // RQ16
        end
        if (amplifier_enable_i) begin
            pa_dig[`SPIO_BIT_OPA_P] = 1'b0; // RQ17
            pb_dig[`SPIO_BIT_OPA_N] = 1'b0; // RQ17
            pb_dig[`SPIO_BIT_OPA_O] = 1'b0; // RQ17
        end
    end

    // pc7:pc6 pick a channel; 11 selects all three
    always @* begin
        chan_sel = 3'h0;
        case (pc_q[`SPIO_BIT_SEL_HI:`SPIO_BIT_SEL_LO])
            2'b00:   chan_sel = 3'h1;
            2'b01:   chan_sel = 3'h2;
            2'b10:   chan_sel = 3'h4;
            default: chan_sel = 3'h7;
        endcase
        pc_pwm  = {W{1'b0}};
        pc_wave = {W{1'b0}};
        for (i = 0; i < 3; i = i + 1) begin
            pc_pwm[2*i]    = true_pulse_out_enable_i & chan_sel[i]; // RQ19
            pc_pwm[2*i+1]  = complement_pulse_out_enable_i & chan_sel[i]; // RQ20
            pc_wave[2*i]   = pulse_i[i];
            pc_wave[2*i+1] = pulse_n_i[i];
        end
    end

    // read value: pin when input, latch when output
    always @* begin
        pa_rd = (pa_dir_q & pa_in_i) | (~pa_dir_q & pa_q); // RQ3 RQ6
        pb_rd = (pb_dir_q & pb_in_i) | (~pb_dir_q & pb_q); // RQ6
        pc_rd = (pc_dir_q & pc_in_i) | (~pc_dir_q & pc_q); // RQ6
        pa_rd = pa_rd & pa_dig;
        pb_rd = pb_rd & pb_dig;
        if (cmp_pin) begin
            pa_rd[`SPIO_BIT_CMP_O] = comparator_out_i; // RQ15
        end
        if (addr_i == `SPIO_ADDR_PA) begin
            rd_d = pa_rd; // RQ1
        end else if (addr_i == `SPIO_ADDR_PA_DIR) begin
            rd_d = pa_dir_q; // RQ2
        end else if (addr_i == `SPIO_ADDR_PB) begin
            rd_d = pb_rd;
        end else if (addr_i == `SPIO_ADDR_PB_DIR) begin
            rd_d = pb_dir_q;
        end else if (addr_i == `SPIO_ADDR_PC) begin
            rd_d = pc_rd;
        end else if (addr_i == `SPIO_ADDR_PC_DIR) begin
            rd_d = pc_dir_q;
        end else if (addr_i == `SPIO_ADDR_PD) begin
            rd_d = {7'h00, pd_dir_q ? pd_in_i : pd_q}; // RQ10
        end else if (addr_i == `SPIO_ADDR_PD_DIR) begin
            rd_d = {7'h00, pd_dir_q}; // RQ10
        end else begin
            rd_d = 8'h00;
        end
    end

    // latches change only on writes; read-modify-write comes back as a write
    always @(posedge mclk_i) begin
        if (srst_i) begin
            pa_q     <= `SPIO_RST_PA;
            pb_q     <= `SPIO_RST_PB;
            pc_q     <= `SPIO_RST_PC;
            pd_q     <= `SPIO_RST_PD;
            pa_dir_q <= `SPIO_RST_DIR; // RQ7
            pb_dir_q <= `SPIO_RST_DIR; // RQ7
            pc_dir_q <= `SPIO_RST_DIR; // RQ7
            pd_dir_q <= 1'b1; // RQ7
        end else if (wr_i) begin
            if (addr_i == `SPIO_ADDR_PA) begin
                pa_q <= wdata_i; // RQ4 RQ8
            end else if (addr_i == `SPIO_ADDR_PA_DIR) begin
                pa_dir_q <= wdata_i;
            end else if (addr_i == `SPIO_ADDR_PB) begin
                pb_q <= wdata_i;
            end else if (addr_i == `SPIO_ADDR_PB_DIR) begin
                pb_dir_q <= wdata_i;
            end else if (addr_i == `SPIO_ADDR_PC) begin
                pc_q <= wdata_i;
            end else if (addr_i == `SPIO_ADDR_PC_DIR) begin
                pc_dir_q <= wdata_i;
            end else if (addr_i == `SPIO_ADDR_PD) begin
                pd_q <= wdata_i[0]; // RQ10
            end else if (addr_i == `SPIO_ADDR_PD_DIR) begin
                pd_dir_q <= wdata_i[0]; // RQ10
            end
        end
    end

    // read data held in a register, sampled on the read cycle
    always @(posedge mclk_i) begin
        if (srst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= rd_d; // RQ3
        end
    end

    // tone divider: half the overflow rate
    always @(posedge mclk_i) begin
        if (srst_i) begin
            tone_q <= 1'b0;
        end else if (tone_tick) begin
            tone_q <= ~tone_q; // RQ13
        end
    end

    // pin drivers, all registered
    always @(posedge mclk_i) begin
        if (srst_i) begin
            pa_out_o  <= {W{1'b0}};
            pa_oe_o   <= {W{1'b0}};
            pa_pull_o <= {W{1'b0}};
            pb_out_o  <= {W{1'b0}};
            pb_oe_o   <= {W{1'b0}};
            pb_pull_o <= {W{1'b0}};
            pc_out_o  <= {W{1'b0}};
            pc_oe_o   <= {W{1'b0}};
            pd_out_o  <= 1'b0;
            pd_oe_o   <= 1'b0;
        end else begin
            pa_out_o  <= pa_q;
            pa_oe_o   <= ~pa_dir_q & pa_dig; // RQ5 RQ16 RQ17
            pa_pull_o <= pa_dig;
            pb_out_o  <= pb_q;
            pb_oe_o   <= ~pb_dir_q & pb_dig; // RQ5 RQ18
            pb_pull_o <= pb_dig;
            pc_out_o  <= (pc_pwm & pc_q & pc_wave) | (~pc_pwm & pc_q); // RQ21
            pc_oe_o   <= ~pc_dir_q; // RQ22
            if (cmp_pin) begin
                // comparator drives the pin itself; latch and pull-up stay off
                pa_oe_o[`SPIO_BIT_CMP_O]   <= 1'b0; // RQ15
                pa_pull_o[`SPIO_BIT_CMP_O] <= 1'b0; // RQ15
            end
            pd_out_o  <= tone_enable_i ? (pd_q & tone_q) : pd_q; // RQ11 RQ12
            pd_oe_o   <= ~pd_dir_q; // RQ11
        end
    end

    // wake on any port a level change
    always @(posedge mclk_i) begin
        if (srst_i) begin
            // idle lines sit high on their pull-ups; a zero here fakes a wake
            pa_prev_q <= {W{1'b1}};
            wake_o    <= 1'b0;
        end else begin
            pa_prev_q <= pa_in_i;
            wake_o    <= |(pa_in_i ^ pa_prev_q); // RQ9
        end
    end

    spio_edge u_edge (
        .mclk_i  (mclk_i),
        .srst_i  (srst_i),
        .arm_i   (cmp_on & ~comparator_pin_out_enable_i), // RQ14
        .level_i (pa_in_i[`SPIO_BIT_CMP_O]),
        .pulse_o (cmp_fall)
    );

    always @(posedge mclk_i) begin
        if (srst_i) begin
            cmp_irq_o <= 1'b0;
        end else begin
            cmp_irq_o <= cmp_fall; // RQ14 RQ24
        end
    end
endmodule

// file: verif/spio_pin_model.sv
// external pin model: driven, pulled-up or floating line per bit
module spio_pin_model #(
    parameter int W = 8
) (
    input  wire logic         mclk_i,
    input  wire logic [W-1:0] out_i,
    input  wire logic [W-1:0] oe_i,
    input  wire logic [W-1:0] pull_i,
    input  wire logic [W-1:0] ext_i,
    input  wire logic [W-1:0] ext_en_i,
    output logic      [W-1:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [W-1:0] flt_q = '0;
    // released line with no pull moves every cycle, never keeps a stale level
    always @(posedge mclk_i) flt_q <= ~flt_q;
    assign pin_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i)
                 | (~oe_i & ~ext_en_i & (pull_i | flt_q));
endmodule

// file: verif/spio_ports_assertions.sv
// concurrent checks on the shared pin i/o port strobes and pins
module spio_ports_assertions #(
    parameter W = 8
) (
    input wire         mclk_i,
    input wire         srst_i,
    input wire [7:0]   addr_i,
    input wire         rd_i,
    input wire [7:0]   rdata_o,
    input wire [W-1:0] pa_in_i,
    input wire [W-1:0] pa_oe_o,
    input wire [W-1:0] pa_pull_o,
    input wire [W-1:0] pb_oe_o,
    input wire [W-1:0] pb_pull_o,
    input wire [W-1:0] pc_oe_o,
    input wire         pd_oe_o,
    input wire         comparator_enable_i,
    input wire         comparator_pin_out_enable_i,
    input wire         amplifier_enable_i,
    input wire [W-1:0] converter_sel_i,
    input wire         cmp_irq_o,
    input wire         wake_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    // four cycles of hold, six for a quiet port a, leave room for registered control paths
    sequence s_cmp_on; comparator_enable_i[*4]; endsequence
    sequence s_cout_on; (comparator_enable_i && comparator_pin_out_enable_i)[*4]; endsequence
    sequence s_amp_on; amplifier_enable_i[*4]; endsequence
    sequence s_conv_held; (converter_sel_i == $past(converter_sel_i))[*4]; endsequence
    sequence s_pa_quiet; $stable(pa_in_i)[*6]; endsequence
    a_reset_all_input: assert property (disable iff (1'b0) srst_i |=>
        !pa_oe_o && !pb_oe_o && !pc_oe_o && !pd_oe_o && !cmp_irq_o)
        else $error("line driven after reset");
    a_irq_one_cycle: assert property (cmp_irq_o |=> !cmp_irq_o)
        else $error("interrupt pulse longer than one cycle");
    a_cmp_pins_off: assert property (s_cmp_on |-> !pa_oe_o[2:1] && !pa_pull_o[2:1])
        else $error("comparator input lines still digital");
    a_cout_no_pull: assert property (s_cout_on |-> !pa_pull_o[3])
        else $error("pull-up on comparator output line");
    a_amp_pins_off: assert property (s_amp_on |-> !pa_oe_o[0] && !pa_pull_o[0]
        && !pb_oe_o[3] && !pb_pull_o[3:2]) else $error("amplifier lines still digital");
    a_conv_no_digital: assert property (s_conv_held |->
        !((pb_oe_o | pb_pull_o) & converter_sel_i)) else $error("converter line digital");
    a_unmapped_zero: assert property (rd_i && (addr_i < 8'h12 || addr_i > 8'h19) |=>
        rdata_o == 8'h00) else $error("unmapped read not zero");
    a_portd_upper_zero: assert property (rd_i && addr_i[7:1] == 7'h0c |=>
        rdata_o[7:1] == 7'h00) else $error("port d upper bits not zero");
    a_wake_needs_change: assert property (s_pa_quiet |-> !wake_o)
        else $error("wake with quiet port a");
endmodule

bind spio_ports spio_ports_assertions #(.W(W)) u_chk (.*);

// file: verif/spio_ports_test.sv
// self-checking bench for the shared pin i/o ports
module spio_ports_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic       mclk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, pd_in_i, pd_out_o, pd_oe_o;
    logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, pa_in_i, pb_in_i, pc_in_i, v, b;
    logic [7:0] pa_out_o, pa_oe_o, pa_pull_o, pb_out_o, pb_oe_o, pb_pull_o, pc_out_o, pc_oe_o;
    logic       comparator_enable_i = 0, comparator_pin_out_enable_i = 0, comparator_out_i = 0;
    logic       amplifier_enable_i = 0, tone_enable_i = 0, tone_src_sel_i = 0, ext_d = 0;
    logic       timer0_ovf_i = 0, timer1_ovf_i = 0, cmp_irq_o, wake_o, pd_prev;
    logic       true_pulse_out_enable_i = 0, complement_pulse_out_enable_i = 0;
    logic [7:0] converter_sel_i = 0, ext [3] = '{8'h5a, 8'ha5, 8'h3c}, tp, ext_en = 8'hff;
    logic [2:0] pulse_i = 0, pulse_n_i = 0;
    int         n_errors = 0, checked = 0, n_irq = 0, n_wake = 0, n_tog = 0, tcnt = 0;
    logic [7:0] po [3], poe [3], rst [3] = '{8'hff, 8'hff, 8'h3f};

    spio_ports dut (.*);
    spio_pin_model u_pa (.mclk_i(mclk_i), .out_i(pa_out_o), .oe_i(pa_oe_o),
        .pull_i(pa_pull_o), .ext_i(ext[0]), .ext_en_i(ext_en), .pin_o(pa_in_i));
    spio_pin_model u_pb (.mclk_i(mclk_i), .out_i(pb_out_o), .oe_i(pb_oe_o),
        .pull_i(pb_pull_o), .ext_i(ext[1]), .ext_en_i(ext_en), .pin_o(pb_in_i));
    spio_pin_model u_pc (.mclk_i(mclk_i), .out_i(pc_out_o), .oe_i(pc_oe_o),
        .pull_i(8'h00), .ext_i(ext[2]), .ext_en_i(ext_en), .pin_o(pc_in_i));
    spio_pin_model #(.W(1)) u_pd (.mclk_i(mclk_i), .out_i(pd_out_o), .oe_i(pd_oe_o),
        .pull_i(1'b0), .ext_i(ext_d), .ext_en_i(1'b1), .pin_o(pd_in_i));

    always @* begin
        po[0] = pa_out_o;
        po[1] = pb_out_o;
        po[2] = pc_out_o;
        poe[0] = pa_oe_o;
        poe[1] = pb_oe_o;
        poe[2] = pc_oe_o;
    end

    always #20 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        n_irq += (cmp_irq_o === 1'b1);
        n_wake += (wake_o === 1'b1);
        n_tog += (pd_out_o !== pd_prev);
        pd_prev <= pd_out_o;
        tcnt <= tcnt + 1;
        if (tcnt == 5000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic close_out;
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    // strobes last one cycle; the idle cycle between calls keeps them apart
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        {addr_i, wdata_i, wr_i} = {a, d, 1'b1};
        @(negedge mclk_i);
        wr_i = 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk_i);
        {addr_i, rd_i} = {a, 1'b1};
        @(negedge mclk_i);
        rd_i = 0;
        d = rdata_o;
    endtask

    initial begin
        cyc(6);
        srst_i = 0;
        for (int k = 0; k < 3; k++) begin
            b = 8'h12 + 8'(2 * k);
            rd(b + 1, v); chk(v, 8'hff);
            rd(b, v); chk(v, ext[k]);
            wr(b + 1, 8'h00); cyc(3); chk(po[k], rst[k]); chk(poe[k], 8'hff);
            wr(b, 8'hc3); wr(b + 1, 8'h0f); cyc(3); chk(poe[k], 8'hf0);
            rd(b, v); chk(v, 8'hc0 | (ext[k] & 8'h0f));
            wr(b, v ^ 8'h01); wr(b + 1, 8'h00); rd(b, v);
            chk(v, (8'hc0 | (ext[k] & 8'h0f)) ^ 8'h01);
        end
        rd(8'h11, v); chk(v, 8'h00);
        rd(8'h1a, v); chk(v, 8'h00);
        rd(8'h18, v); chk(v, 8'h00);
        wr(8'h19, 8'hfe); wr(8'h18, 8'hff); rd(8'h19, v); chk(v, 8'h00);
        rd(8'h18, v); chk(v, 8'h01);
        cyc(2); chk({pd_oe_o, pd_out_o}, 8'h03);
        $display("test ports done");
        tone_enable_i = 1;
        for (int s = 0; s < 2; s++) begin
            tone_src_sel_i = 1'(s); cyc(4); n_tog = 0;
            for (int i = 0; i < 8; i++) begin
                {timer1_ovf_i, timer0_ovf_i} = 2'(i % 2 + 1); cyc(1);
                {timer1_ovf_i, timer0_ovf_i} = 2'b00; cyc(4);
            end
            chk(8'(n_tog), 8'h04);
        end
        tone_src_sel_i = 0;
        wr(8'h18, 8'h00); timer0_ovf_i = 1; cyc(1); timer0_ovf_i = 0; cyc(4);
        chk(pd_out_o, 8'h00);
        tone_enable_i = 0;
        $display("test tone done");
        {true_pulse_out_enable_i, complement_pulse_out_enable_i} = 2'b11;
        for (int s = 0; s < 4; s++) begin
            tp = (s == 3) ? 8'h07 : 8'h01 << s;
            complement_pulse_out_enable_i = 1;
            wr(8'h16, {2'(s), 6'h3f}); cyc(3);
            chk(pc_out_o, {2'(s), ~{tp[2], tp[2], tp[1], tp[1], tp[0], tp[0]}});
            complement_pulse_out_enable_i = 0; cyc(3);
            chk(pc_out_o, {2'(s), 1'b1, ~tp[2], 1'b1, ~tp[1], 1'b1, ~tp[0]});
        end
        complement_pulse_out_enable_i = 1; pulse_i = 3'b111;
        wr(8'h16, 8'h3f); cyc(3); chk(pc_out_o, 8'h3d);
        wr(8'h16, 8'h3e); cyc(3); chk(pc_out_o, 8'h3c);
        wr(8'h17, 8'h01); cyc(3); chk(pc_oe_o, 8'hfe);
        $display("test pulse done");
        wr(8'h13, 8'hff); comparator_enable_i = 1; ext[0] = 8'h0e; cyc(6); n_irq = 0;
        ext[0] = 8'h06; cyc(10); chk(8'(n_irq), 8'h01);
        comparator_pin_out_enable_i = 1; comparator_out_i = 1; cyc(4);
        rd(8'h12, v); chk(v & 8'h0e, 8'h08);
        comparator_out_i = 0; cyc(4); rd(8'h12, v); chk(v & 8'h0e, 8'h00);
        {comparator_enable_i, comparator_pin_out_enable_i} = 2'b00;
        n_wake = 0; ext[0] = 8'h80; cyc(8); chk(8'(n_wake != 0), 8'h01);
        amplifier_enable_i = 1; converter_sel_i = 8'h30; cyc(6);
        chk(pb_oe_o & 8'h3c, 8'h00);
        chk(pb_pull_o & 8'h3c, 8'h00);
        {amplifier_enable_i, converter_sel_i} = 9'h000; cyc(4);
        // mid-run reset: lines go back to inputs, port a held up by its pulls
        srst_i = 1; cyc(2); srst_i = 0; ext_en = 8'h00;
        rd(8'h17, v); chk(v, 8'hff); chk(pc_oe_o, 8'h00);
        rd(8'h12, v); chk(v, 8'hff);
        $display("test analog done");
        close_out();
    end
endmodule
